// ===== hw/twm_master.sv
// Two-wire serial bus master: byte engine, open-drain pins, arbitration
`timescale 1ns/1ns
`default_nettype none

module twm_master
  import twm_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     arst_n_i,
  input  wire logic     fast_mode_i,
  input  wire logic     cmd_valid_i,
  input  wire twm_cmd_t cmd_i,
  output logic          cmd_ready_o,
  output logic          rsp_valid_o,
  output twm_rsp_t      rsp_o,
  output logic          bus_busy_o,
  input  wire logic     scl_i,
  output logic          scl_o,
  output logic          scl_oe_o,
  input  wire logic     sda_i,
  output logic          sda_o,
  output logic          sda_oe_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_ACK, ST_STOP, ST_HOLD
  } twm_state_t;

  // ----------------------------------------------------------------------
  // Pin synchronisers and bus watch
  // ----------------------------------------------------------------------
  logic scl_m_ff, scl_s_ff, scl_d_ff;
  logic sda_m_ff, sda_s_ff, sda_d_ff;
  logic busy_ff;

  // Three flops per pin; only the second and later stages feed logic
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
      {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
    end else begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= {scl_i, scl_m_ff, scl_s_ff};
      {sda_m_ff, sda_s_ff, sda_d_ff} <= {sda_i, sda_m_ff, sda_s_ff};
    end
  end

  // Start and stop seen on the wire, ours or another master's
  wire start_seen_w = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  wire stop_seen_w  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

  // Busy between any start and stop, so we never barge into a message
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_ff <= 1'b0;
    end else if (start_seen_w) begin
      busy_ff <= 1'b1;
    end else if (stop_seen_w) begin
      busy_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Quarter-bit timing engine
  // ----------------------------------------------------------------------
  twm_state_t        st_ff, nxt_st;
  logic [1:0]        q_ff;
  logic [QCNT_W-1:0] qcnt_ff;
  logic [2:0]        bit_ff;
  logic [7:0]        shift_ff;
  twm_op_t           op_ff;
  logic              nack_ff, fast_ff, samp_ff, err_ff;
  logic              ready_ff, rsp_valid_ff, scl_oe_ff, sda_oe_ff;
  twm_rsp_t          rsp_ff;

  wire active_w = st_ff inside {ST_START, ST_DATA, ST_ACK, ST_STOP};
  wire cmd_fire_w = cmd_valid_i & ready_ff;
  wire tx_w = op_ff inside {OP_START, OP_WRITE};

  // Rate is latched per command so a byte never changes speed midway
  wire [QCNT_W-1:0] qlim_w = fast_ff ? FAST_QTR_LIM : STD_QTR_LIM;

  // Released clock held low by a slow slave: freeze the count
  wire stall_w = active_w & (q_ff == 2'h2) & ~scl_s_ff;
  // Another master pulling clock low early ends our high phase
  wire sync_cut_w = active_w & (q_ff == 2'h3) & ~scl_s_ff;
  wire qdone_w = active_w &
                 ((~stall_w & (qcnt_ff == qlim_w)) | sync_cut_w);
  wire sample_w = qdone_w & (q_ff == 2'h2);
  wire pend_w = qdone_w & (q_ff == 2'h3);

  // Sent a released one but the line reads low: bus lost
  wire arb_lost_w = sample_w & (st_ff == ST_DATA) & tx_w &
                    shift_ff[7] & ~sda_s_ff;
  wire ack_bad_w = (st_ff == ST_ACK) & pend_w & tx_w & samp_ff;
  wire refuse_w = cmd_fire_w & (st_ff == ST_IDLE) &
                  (cmd_i.op != OP_START);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (cmd_fire_w && cmd_i.op == OP_START) begin
          nxt_st = ST_START;
        end
      end
      ST_HOLD: begin
        if (cmd_fire_w) begin
          unique case (cmd_i.op)
            OP_START: nxt_st = ST_START;
            OP_WRITE: nxt_st = ST_DATA;
            OP_READ:  nxt_st = ST_DATA;
            OP_STOP:  nxt_st = ST_STOP;
          endcase
        end
      end
      ST_START: begin
        if (pend_w) begin
          nxt_st = ST_DATA;
        end
      end
      ST_DATA: begin
        if (arb_lost_w) begin
          nxt_st = ST_IDLE;
        end else if (pend_w && bit_ff == LAST_BIT) begin
          nxt_st = ST_ACK;
        end
      end
      ST_ACK: begin
        if (ack_bad_w) begin
          nxt_st = ST_STOP;
        end else if (pend_w) begin
          nxt_st = ST_HOLD;
        end
      end
      ST_STOP: begin
        if (pend_w) begin
          nxt_st = ST_IDLE;
        end
      end
    endcase
  end

  // Answer at the end of each command, on refusal, or on a lost bus
  wire rsp_go_w = refuse_w | arb_lost_w | (st_ff == ST_STOP & pend_w) |
                  (st_ff == ST_ACK & pend_w & ~ack_bad_w);
  wire twm_rsp_t nxt_rsp = '{data:     shift_ff,
                             ack_err:  refuse_w |
                                       (st_ff == ST_STOP & err_ff),
                             arb_lost: arb_lost_w};
  wire nxt_ready_w = (nxt_st == ST_HOLD) |
                     (nxt_st == ST_IDLE & ~busy_ff & ~start_seen_w);

  // Byte to load for a new command
  wire [7:0] load_byte_w =
    (cmd_i.op == OP_START) ? twm_addr_byte(cmd_i.addr, cmd_i.dir) :
    (cmd_i.op == OP_WRITE) ? cmd_i.data : BYTE_IDLE;

  // ----------------------------------------------------------------------
  // Line drive decode
  // ----------------------------------------------------------------------
  // Clock low in the first half of every bit and while holding the bus
  wire scl_low_w = (active_w & ~q_ff[1]) | (st_ff == ST_HOLD);
  // Data is updated only in idle and in quarter one (clock low) except at the
  // start and stop edges; holding keeps it, so nothing moves on entry
  wire sda_upd_w = (st_ff == ST_IDLE) | (active_w & q_ff == 2'h1) |
                   ((st_ff inside {ST_START, ST_STOP}) & q_ff == 2'h3);
  logic sda_low_w;
  always_comb begin
    sda_low_w = 1'b0;
    unique case (st_ff)
      ST_START: sda_low_w = (q_ff == 2'h3);
      ST_DATA:  sda_low_w = tx_w & ~shift_ff[7];
      ST_ACK:   sda_low_w = ~tx_w & ~nack_ff;
      ST_STOP:  sda_low_w = (q_ff != 2'h3);
      ST_IDLE:  sda_low_w = 1'b0;
      ST_HOLD:  sda_low_w = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // State and quarter counter
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff   <= ST_IDLE;
      q_ff    <= 2'h0;
      qcnt_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      if (nxt_st != st_ff || !active_w) begin
        q_ff    <= 2'h0;
        qcnt_ff <= '0;
      end else if (qdone_w) begin
        q_ff    <= q_ff + 2'h1;
        qcnt_ff <= '0;
      end else if (!stall_w) begin
        qcnt_ff <= qcnt_ff + QCNT_W'(1);
      end
    end
  end

  // Command capture and byte shifter
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_ff    <= OP_STOP;
      nack_ff  <= 1'b0;
      fast_ff  <= 1'b0;
      shift_ff <= BYTE_IDLE;
      bit_ff   <= 3'h0;
      samp_ff  <= 1'b1;
    end else if (cmd_fire_w) begin
      op_ff    <= cmd_i.op;
      nack_ff  <= cmd_i.nack;
      fast_ff  <= fast_mode_i;
      shift_ff <= load_byte_w;
      bit_ff   <= 3'h0;
    end else begin
      if (sample_w) begin
        samp_ff <= sda_s_ff;
      end
      if (st_ff == ST_DATA && pend_w) begin
        shift_ff <= {shift_ff[6:0], samp_ff};
        bit_ff   <= bit_ff + 3'h1;
      end
    end
  end

  // Error flag; a new command clears it, a missing acknowledge sets it
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_ff <= 1'b0;
    end else if (ack_bad_w) begin
      err_ff <= 1'b1;
    end else if (cmd_fire_w) begin
      err_ff <= 1'b0;
    end
  end

  // Handshake, response and pins
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_ff     <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_ff       <= '0;
      scl_oe_ff    <= 1'b0;
      sda_oe_ff    <= 1'b0;
    end else begin
      ready_ff     <= nxt_ready_w;
      rsp_valid_ff <= rsp_go_w;
      if (rsp_go_w) begin
        rsp_ff <= nxt_rsp;
      end
      scl_oe_ff <= scl_low_w;
      if (sda_upd_w) begin
        sda_oe_ff <= sda_low_w;
      end
    end
  end

  // Open drain: the output level is always low, only the enable moves
  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe_o    = scl_oe_ff;
  assign sda_oe_o    = sda_oe_ff;
  assign cmd_ready_o = ready_ff;
  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_o       = rsp_ff;
  assign bus_busy_o  = busy_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_start_shape: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    $rose(sda_oe_ff) && !scl_oe_ff |->
      $past(st_ff) == ST_START && $past(q_ff) == 2'h3)
    else $error("data pulled low under high clock outside start");

  chk_sda_stable: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    $fell(sda_oe_ff) && !scl_oe_ff && $past(!scl_oe_ff) |->
      $past(st_ff) inside {ST_STOP, ST_IDLE})
    else $error("data released under high clock outside stop");

  chk_addr_load: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    cmd_fire_w && cmd_i.op == OP_START |=>
      shift_ff == {$past(cmd_i.addr), $past(cmd_i.dir)} &&
      st_ff == ST_START)
    else $error("address byte not formed from address and direction");

  chk_nack_stop: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    st_ff == ST_ACK && pend_w && tx_w && samp_ff |=>
      st_ff == ST_STOP && err_ff && !ready_ff)
    else $error("missing acknowledge did not lead to stop");

  chk_stop_resp: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    st_ff == ST_STOP && pend_w |=>
      st_ff == ST_IDLE && rsp_valid_ff && !sda_oe_ff && !scl_oe_ff)
    else $error("stop did not end with both lines released");

  chk_stretch_hold: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    stall_w |=> qcnt_ff == $past(qcnt_ff) && q_ff == 2'h2)
    else $error("bit timing ran on while clock held low");

  chk_byte_ack: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    st_ff == ST_DATA && pend_w && bit_ff == LAST_BIT && !arb_lost_w |=>
      st_ff == ST_ACK)
    else $error("acknowledge slot not after eighth bit");

  chk_rate_limit: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    active_w |-> qlim_w == (fast_ff ? 9'h04E : 9'h138))
    else $error("quarter bit length wrong for selected rate");

  chk_arb_release: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    arb_lost_w |=> st_ff == ST_IDLE ##1 !scl_oe_ff && !sda_oe_ff)
    else $error("lines not released after losing arbitration");

  chk_read_release: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    st_ff == ST_DATA && !tx_w && q_ff[1] |-> !sda_oe_ff)
    else $error("master drives data while slave transmits");

  chk_clock_drive: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    active_w && ((q_ff == 2'h0 && qcnt_ff != '0) || q_ff == 2'h1) |->
      scl_oe_ff)
    else $error("clock not pulled low in low half of bit");

  chk_msb_first: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    st_ff == ST_DATA && pend_w |=>
      shift_ff == {$past(shift_ff[6:0]), $past(samp_ff)})
    else $error("byte not shifted most significant bit first");

  chk_open_drain: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    scl_oe_o || sda_oe_o |-> !scl_o && !sda_o)
    else $error("line driven high");

endmodule

`default_nettype wire

// ===== hw/twm_pkg.sv
// Shared constants and types for the two-wire bus master
package twm_pkg;

  // ----------------------------------------------------------------------
  // Clock and bus rate timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;       // System clock, 125 MHz
  localparam int STD_BIT_NS    = 10000;   // Standard rate, 100 kbit/s
  localparam int FAST_BIT_NS   = 2500;    // Fast rate, 400 kbit/s
  // Each bit is four equal quarters; a least time, so round up
  localparam int STD_QTR_CYC   =
    (STD_BIT_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAST_QTR_CYC  =
    (FAST_BIT_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QCNT_W        = 9;
  localparam logic [QCNT_W-1:0] STD_QTR_LIM  = QCNT_W'(STD_QTR_CYC - 1);
  localparam logic [QCNT_W-1:0] FAST_QTR_LIM = QCNT_W'(FAST_QTR_CYC - 1);

  // ----------------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------------
  localparam logic [2:0] LAST_BIT  = 3'h7;   // Eighth bit of a byte
  localparam logic       DIR_WRITE = 1'b0;
  localparam logic       DIR_READ  = 1'b1;
  localparam logic [7:0] BYTE_IDLE = 8'hFF;  // Released line while reading

  // ----------------------------------------------------------------------
  // Command and response carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_START,   // Start (or repeated start) plus address byte
    OP_WRITE,   // Send one data byte
    OP_READ,    // Receive one data byte
    OP_STOP     // Stop condition
  } twm_op_t;

  typedef struct packed {
    twm_op_t    op;
    logic [6:0] addr;   // Slave address for OP_START
    logic       dir;    // DIR_WRITE or DIR_READ for OP_START
    logic [7:0] data;   // Byte for OP_WRITE
    logic       nack;   // OP_READ: answer with no acknowledge
  } twm_cmd_t;

  typedef struct packed {
    logic [7:0] data;      // Byte read back from the line
    logic       ack_err;   // Missing acknowledge, or refused command
    logic       arb_lost;  // Another master won the bus
  } twm_rsp_t;

  // Address in the upper seven bits, direction in the lowest bit
  function automatic logic [7:0] twm_addr_byte(input logic [6:0] addr,
                                               input logic       dir);
    return {addr, dir};
  endfunction

endpackage

// ===== verification/twm_slave_model.sv
// Behavioural addressed slave standing on the far side of the bus
`timescale 1ns/1ns
`default_nettype none

module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       stretch_i,
  input  wire logic [7:0] rd_byte_i,
  output logic            scl_pull_o,
  output logic            sda_pull_o,
  output logic [7:0]      got_o
);
  int         cnt;
  logic       first;
  logic       sel;
  logic       rd;
  logic       mack;
  logic       drv;
  logic [7:0] sh;
  logic [7:0] tx;

  // Pins only pull low or let go; the pull-up makes them high
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    got_o = 8'h00;
    cnt = 0;
    first = 1'b0;
    sel = 1'b0;
    drv = 1'b0;
  end

  // A start restarts the framing; a stop deselects the slave
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    cnt = 0;
    first = 1'b1;
    drv = 1'b0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    sel = 1'b0;
    drv = 1'b0;
  end

  // Bits are taken on the rising clock, most significant first
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else mack = sda_i;
    cnt = cnt + 1;
  end

  // Changes land shortly after the clock falls, never while it is high
  always @(negedge scl_i) begin
    #100;
    if (cnt == 8) begin
      if (first) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end
      got_o = sh;
      sda_pull_o = sel && (first || !rd);
    end else if (cnt == 9) begin
      cnt = 0;
      first = 1'b0;
      tx = rd_byte_i;
      drv = sel && rd && !mack;
      sda_pull_o = drv && !tx[7];
      // Holding the clock low tests that the master really waits
      if (stretch_i) begin
        scl_pull_o = 1'b1;
        #8000;
        scl_pull_o = 1'b0;
      end
    end else if (cnt < 8) begin
      sda_pull_o = drv && !tx[7-cnt];
    end
  end
endmodule

`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the two-wire bus master
`timescale 1ns/1ns
`default_nettype none

module tb
  import twm_pkg::*;
;
  logic       clock_i;
  logic       arst_n_i;
  logic       fast_mode_i;
  logic       cmd_valid_i;
  logic       stretch;
  twm_cmd_t   cmd_i;
  twm_rsp_t   rsp_o;
  twm_rsp_t   rsp;
  logic       cmd_ready_o;
  logic       rsp_valid_o;
  logic       bus_busy_o;
  logic       scl_oe_o;
  logic       sda_oe_o;
  logic       s_scl;
  logic       s_sda;
  logic [7:0] got;
  wire logic  scl_w;
  wire logic  sda_w;
  int         n_mismatch;
  int         compares;
  int         n_start;
  int         n_stop;
  int         cyc;

  // Open-drain wires with pull-ups: low while anyone pulls
  assign scl_w = ~(scl_oe_o | s_scl);
  assign sda_w = ~(sda_oe_o | s_sda);

  twm_master dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .fast_mode_i(fast_mode_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .bus_busy_o(bus_busy_o),
    .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe_o),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o));

  twm_slave_model slave (
    .scl_i(scl_w), .sda_i(sda_w), .stretch_i(stretch),
    .rd_byte_i(8'h3C), .scl_pull_o(s_scl), .sda_pull_o(s_sda),
    .got_o(got));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Wire monitors: data edges while the clock is high frame a message
  always @(negedge sda_w) if (scl_w === 1'b1) n_start++;
  always @(posedge sda_w) if (scl_w === 1'b1) n_stop++;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, v);
    compares++;
    if (v !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, v);
    end
  endtask

  // One command: wait for ready, hold it one edge, await the answer
  task automatic run(input twm_op_t o, input logic [6:0] a,
                     input logic d, input logic [7:0] b, input logic k);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1) begin
      n++;
      if (n > 50) begin
        chk("ready", 1, 0);
        test_done();
      end
      @(negedge clock_i);
    end
    cmd_i = '{op: o, addr: a, dir: d, data: b, nack: k};
    cmd_valid_i = 1'b1;
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
    cyc = 0;
    while (rsp_valid_o !== 1'b1) begin
      cyc++;
      if (cyc > 20000) begin
        chk("response", 1, 0);
        test_done();
      end
      @(negedge clock_i);
    end
    rsp = rsp_o;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Write with a stretched clock, then stop
  task automatic t_write();
    int s0;
    int p0;
    s0 = n_start;
    p0 = n_stop;
    fast_mode_i = 1'b1;
    stretch = 1'b1;
    run(OP_START, 7'h2A, DIR_WRITE, 8'h00, 1'b0);
    chk("address ack", 0, rsp.ack_err);
    chk("arbitration", 0, rsp.arb_lost);
    chk("address byte", 8'h54, got);
    chk("start seen", 1, n_start - s0);
    chk("busy", 1, bus_busy_o);
    chk("fast time", 1, cyc >= 3160 && cyc < 12500);
    // The slave holds the clock after the address acknowledge; drop the
    // request only once the write has been answered
    run(OP_WRITE, 7'h00, 1'b0, 8'hA5, 1'b0);
    stretch = 1'b0;
    chk("data byte", 8'hA5, got);
    chk("data ack", 0, rsp.ack_err);
    chk("stretched time", 1, cyc >= 3400);
    run(OP_STOP, 7'h00, 1'b0, 8'h00, 1'b0);
    repeat (10) @(negedge clock_i);
    chk("stop seen", 1, n_stop - p0);
    chk("idle", 0, bus_busy_o);
  endtask

  // Read one byte, refusing it with no acknowledge
  task automatic t_read();
    run(OP_START, 7'h2A, DIR_READ, 8'h00, 1'b0);
    chk("read address", 8'h55, got);
    run(OP_READ, 7'h00, 1'b0, 8'h00, 1'b1);
    chk("read data", 8'h3C, rsp.data);
    run(OP_STOP, 7'h00, 1'b0, 8'h00, 1'b0);
  endtask

  // Unanswered address at the standard rate, then idle commands
  task automatic t_nack();
    twm_op_t ops[3];
    int p0;
    ops = '{OP_WRITE, OP_READ, OP_STOP};
    p0 = n_stop;
    fast_mode_i = 1'b0;
    run(OP_START, 7'h11, DIR_WRITE, 8'h00, 1'b0);
    chk("missing ack", 1, rsp.ack_err);
    chk("std time", 1, cyc >= 12500);
    repeat (10) @(negedge clock_i);
    chk("abort stop", 1, n_stop - p0);
    chk("abort idle", 0, bus_busy_o);
    foreach (ops[i]) begin
      run(ops[i], 7'h2A, 1'b0, 8'h0F, 1'b0);
      chk("refused", 1, rsp.ack_err);
      chk("refused time", 1, cyc <= 2);
      chk("no start", 0, bus_busy_o);
    end
  endtask

  initial begin
    arst_n_i = 1'b0;
    fast_mode_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    stretch = 1'b0;
    n_mismatch = 0;
    compares = 0;
    n_start = 0;
    n_stop = 0;
    repeat (6) @(negedge clock_i);
    arst_n_i = 1'b1;
    @(negedge clock_i);
    t_write();
    t_read();
    t_nack();
    test_done();
  end
endmodule

`default_nettype wire
